// file: svf_host.sv
// host model driving the register port
`timescale 1ns/1ps
module svf_host (
  // clock
  input wire logic clk,
  // register port
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // no pop-sensitive outputs here
  // one access, held to its edge, then a gap
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    @(posedge clk);
  endtask
endmodule

// file: svf_pkg.sv
// shared constants and types for the soft volume and fine gain block
package svf_pkg;
  // register offsets
  localparam logic [7:0] RISE_RATE_OFS = 8'h37;
  localparam logic [7:0] FALL_RATE_OFS = 8'h38;
  localparam logic [7:0] CH_FINE_OFS = 8'h3F;
  localparam logic [7:0] MASTER_FINE_OFS = 8'h40;
  // reset values
  localparam logic [7:0] RISE_RATE_RST = 8'h00;
  localparam logic [7:0] FALL_RATE_RST = 8'h00;
  localparam logic [7:0] CH_FINE_RST = 8'h80;
  localparam logic [7:0] MASTER_FINE_RST = 8'h00;
  // field positions
  localparam int RATE_EN_BIT = 5;
  localparam int RATE_DIV_LSB = 0;
  localparam int FINE_EN_BIT = 7;
  localparam int FINE_DEFER_BIT = 6;
  localparam int FINE_FIELD_W = 2;
  localparam int NUM_CH = 3;
  // gain arithmetic: eighth-dB units, coarse steps are 0.5 dB
  localparam int COARSE_SHIFT = 2;
  localparam int ATTEN_W = 12;
  // timing: max rate 48 dB/ms in 0.125 dB steps
  localparam int MAX_RATE_DB_PER_MS = 48;
  localparam int STEPS_PER_DB = 8;
  localparam int MS_NS = 1000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_CYC = MS_NS / (CLK_PERIOD_NS * MAX_RATE_DB_PER_MS * STEPS_PER_DB);
  // default rate divisor, 12 dB/ms in both directions
  localparam logic [4:0] DEFAULT_DIVISOR = 5'h03;

  typedef struct packed {
    logic override_en;
    logic [4:0] divisor;
  } svf_rate_cfg_s;
endpackage

// file: svf_ramp_chan.sv
// one channel soft gain ramp toward its target
`timescale 1ns/1ps
module svf_ramp_chan #(
  parameter int W = svf_pkg::ATTEN_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  // target attenuation and rates
  input wire logic [W-1:0] target,
  input wire svf_pkg::svf_rate_cfg_s rise_cfg,
  input wire svf_pkg::svf_rate_cfg_s fall_cfg,
  // ramped attenuation
  output logic [W-1:0] gain
);
  if (W < 4) begin : g_chk
    $error("svf_ramp_chan: W too small");
  end

  logic [W-1:0] gain_r;
  logic [4:0] cnt_r;
  // lower attenuation means volume rising
  wire going_up = target < gain_r;
  wire at_target = gain_r == target;
  // [RQ2] rise rate select
  wire [4:0] div_up = rise_cfg.override_en ? rise_cfg.divisor : svf_pkg::DEFAULT_DIVISOR;
  // [RQ4] fall rate select
  wire [4:0] div_dn = fall_cfg.override_en ? fall_cfg.divisor : svf_pkg::DEFAULT_DIVISOR;
  // [RQ12] direction picks rate
  wire [4:0] div_sel = going_up ? div_up : div_dn;
  // [RQ3] step every N+1 ticks
  wire step = tick && !at_target && (cnt_r >= div_sel);
  wire [4:0] cnt_nxt = (at_target || step) ? 5'h00 : (tick ? cnt_r + 5'h01 : cnt_r);
  // [RQ12] one unit toward target
  wire [W-1:0] gain_nxt = !step ? gain_r : (going_up ? gain_r - 1'b1 : gain_r + 1'b1);

  always_ff @(posedge clk) begin
    if (rst) begin
      gain_r <= '0;
      cnt_r <= 5'h00;
    end else begin
      gain_r <= gain_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign gain = gain_r;

  a_hold_at_target: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    at_target && $stable(target) |=> gain_r == $past(gain_r))
    else $error("gain moved while at target");
  a_unit_step_toward: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    gain_r != $past(gain_r) |-> (gain_r == $past(gain_r) + 1'b1 && $past(!going_up))
      || (gain_r == $past(gain_r) - 1'b1 && $past(going_up)))
    else $error("gain step wrong size or direction");
  a_rise_rate_override: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    step && going_up && rise_cfg.override_en |-> cnt_r >= rise_cfg.divisor)
    else $error("rise step earlier than programmed rate");
  a_fall_rate_override: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    step && !going_up && fall_cfg.override_en |-> cnt_r >= fall_cfg.divisor)
    else $error("fall step earlier than programmed rate");
  a_default_rate_both: assert property (@(posedge clk) disable iff (rst) // [RQ13]
    step && !(going_up ? rise_cfg.override_en : fall_cfg.override_en)
      |-> cnt_r == svf_pkg::DEFAULT_DIVISOR)
    else $error("default rate not applied");
  a_step_on_tick: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    gain_r != $past(gain_r) |-> $past(tick))
    else $error("gain stepped without tick");
endmodule

// file: svf_tick_div.sv
// base step tick divider
`timescale 1ns/1ps
module svf_tick_div #(
  parameter int PERIOD = svf_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // one-cycle tick
  output logic tick
);
  if (PERIOD < 1 || PERIOD > 65536) begin : g_chk
    $error("svf_tick_div: PERIOD must be 1 to 65536");
  end

  logic [15:0] cnt_r;
  wire last = (cnt_r == 16'(PERIOD - 1));

  always_ff @(posedge clk) begin
    if (rst || last) cnt_r <= 16'h0000;
    else cnt_r <= cnt_r + 16'h0001;
  end

  assign tick = last;

  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    (PERIOD > 1) && tick |=> !tick) else $error("tick pulses back to back");
endmodule

// file: svf_top.sv
// soft volume ramping with fine gain, top level
//
// Contract
// [RQ1] Volume changes ramp at a built-in rate unless the rate registers override it.
// [RQ2] A rising volume uses the default rate unless rise override is set, then the rise divisor.
// [RQ3] With rise override set the rise rate is 48/(N+1) dB per ms.
// [RQ4] A falling volume uses the default rate unless fall override is set, then the fall divisor.
// [RQ5] With fall override set the fall rate is 48/(N+1) dB per ms.
// [RQ6] The host should clear output and zero-cross enables for fall rates above 6 dB per ms.
// [RQ7] With fine gain enabled each gain is coarse plus fine offset in 0.125 dB units.
// [RQ8] With fine gain disabled only coarse gains count, whatever the deferred bit holds.
// [RQ9] A fine code of 00, 01, 10, 11 means 0, -0.125, -0.25, -0.375 dB.
// [RQ10] With deferred apply clear a new fine offset takes effect as soon as it is written.
// [RQ11] With deferred apply set a new fine offset waits for a write of its coarse register.
// [RQ12] Each channel ramps toward its target by direction-selected rate and stops on it.
// [RQ13] The default rate is one constant used for both directions.
`timescale 1ns/1ps
module svf_top #(
  parameter int TICK_CYC = svf_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // coarse gains and their write strobes
  input wire logic [2:0][7:0] CH_COARSE_GAIN,
  input wire logic [2:0] CH_COARSE_WR,
  input wire logic [7:0] MASTER_COARSE_GAIN,
  input wire logic MASTER_COARSE_WR,
  // ramped attenuation, 0.125 dB units
  output logic [2:0][11:0] CH_ATTEN
);
  localparam int NCH = svf_pkg::NUM_CH;
  localparam int AW = svf_pkg::ATTEN_W;
  if (TICK_CYC < 1) begin : g_chk
    $error("svf_top: TICK_CYC must be at least 1");
  end

  logic [7:0] rise_r;
  logic [7:0] fall_r;
  logic [7:0] ch_fine_r;
  logic [7:0] master_fine_r;
  logic [7:0] rdata_r;
  logic [NCH-1:0][1:0] fine_act_r;
  logic [NCH-1:0][1:0] fine_act_nxt;
  logic [1:0] mfine_act_r;
  logic tick;

  // register decode
  wire wr_rise = REG_WR && (REG_ADDR == svf_pkg::RISE_RATE_OFS);
  wire wr_fall = REG_WR && (REG_ADDR == svf_pkg::FALL_RATE_OFS);
  wire wr_chf = REG_WR && (REG_ADDR == svf_pkg::CH_FINE_OFS);
  wire wr_mf = REG_WR && (REG_ADDR == svf_pkg::MASTER_FINE_OFS);
  wire [7:0] rd_sel = (REG_ADDR == svf_pkg::RISE_RATE_OFS) ? rise_r :
                      (REG_ADDR == svf_pkg::FALL_RATE_OFS) ? fall_r :
                      (REG_ADDR == svf_pkg::CH_FINE_OFS) ? ch_fine_r :
                      (REG_ADDR == svf_pkg::MASTER_FINE_OFS) ? master_fine_r : 8'h00;

  wire fine_en = ch_fine_r[svf_pkg::FINE_EN_BIT];
  wire fine_defer = ch_fine_r[svf_pkg::FINE_DEFER_BIT];

  // [RQ2] rise config fields
  wire svf_pkg::svf_rate_cfg_s rise_cfg = rise_r[svf_pkg::RATE_EN_BIT:svf_pkg::RATE_DIV_LSB];
  // [RQ4] fall config fields
  wire svf_pkg::svf_rate_cfg_s fall_cfg = fall_r[svf_pkg::RATE_EN_BIT:svf_pkg::RATE_DIV_LSB];

  // [RQ10] immediate or [RQ11] deferred fine apply
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (!fine_defer || CH_COARSE_WR[i]) fine_act_nxt[i] = ch_fine_r[2*i +: 2];
      else fine_act_nxt[i] = fine_act_r[i];
    end
  end
  wire [1:0] mfine_act_nxt = (!fine_defer || MASTER_COARSE_WR) ? master_fine_r[1:0] : mfine_act_r;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rise_r <= svf_pkg::RISE_RATE_RST;
      fall_r <= svf_pkg::FALL_RATE_RST;
      ch_fine_r <= svf_pkg::CH_FINE_RST;
      master_fine_r <= svf_pkg::MASTER_FINE_RST;
      rdata_r <= 8'h00;
      fine_act_r <= '0;
      mfine_act_r <= 2'h0;
    end else begin
      if (wr_rise) rise_r <= {2'h0, REG_WDATA[5:0]};
      if (wr_fall) fall_r <= {2'h0, REG_WDATA[5:0]};
      if (wr_chf) ch_fine_r <= REG_WDATA;
      if (wr_mf) master_fine_r <= {6'h00, REG_WDATA[1:0]};
      if (REG_RD) rdata_r <= rd_sel;
      fine_act_r <= fine_act_nxt;
      mfine_act_r <= mfine_act_nxt;
    end
  end

  assign REG_RDATA = rdata_r;

  // [RQ9] fine code equals eighth-dB attenuation
  wire [AW-1:0] mfine_att = fine_en ? AW'(mfine_act_r) : '0;
  wire [AW-1:0] master_att = AW'({MASTER_COARSE_GAIN, 2'b00}) + mfine_att;
  logic [NCH-1:0][AW-1:0] target;

  svf_tick_div #(
    .PERIOD(TICK_CYC)
  ) u_tick (
    .clk(MCLK),
    .rst(RST),
    .tick(tick)
  );

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    // [RQ7] coarse plus fine, [RQ8] fine dropped when disabled
    assign target[g] = AW'({CH_COARSE_GAIN[g], 2'b00})
                     + (fine_en ? AW'(fine_act_r[g]) : AW'(0)) + master_att;

    // [RQ1] ramp at default or programmed rate
    svf_ramp_chan #(
      .W(AW)
    ) u_ramp (
      .clk(MCLK),
      .rst(RST),
      .tick(tick),
      .target(target[g]),
      .rise_cfg(rise_cfg),
      .fall_cfg(fall_cfg),
      .gain(CH_ATTEN[g])
    );

    a_fine_sum_on: assert property (@(posedge MCLK) disable iff (RST) // [RQ7]
      fine_en |-> target[g] == AW'(CH_COARSE_GAIN[g]) * 4 + AW'(fine_act_r[g])
        + AW'(MASTER_COARSE_GAIN) * 4 + AW'(mfine_act_r))
      else $error("fine target sum wrong");
    a_fine_off_coarse: assert property (@(posedge MCLK) disable iff (RST) // [RQ8]
      !fine_en |-> target[g] == AW'(CH_COARSE_GAIN[g]) * 4 + AW'(MASTER_COARSE_GAIN) * 4)
      else $error("fine offset leaked while disabled");
    a_immediate_apply: assert property (@(posedge MCLK) disable iff (RST) // [RQ10]
      !fine_defer |=> fine_act_r[g] == $past(ch_fine_r[2*g +: 2]))
      else $error("fine offset not applied at once");
    a_deferred_hold: assert property (@(posedge MCLK) disable iff (RST) // [RQ11]
      fine_defer && !CH_COARSE_WR[g] |=> fine_act_r[g] == $past(fine_act_r[g]))
      else $error("deferred fine offset applied early");
    a_deferred_take: assert property (@(posedge MCLK) disable iff (RST) // [RQ11]
      fine_defer && CH_COARSE_WR[g] |=> fine_act_r[g] == $past(ch_fine_r[2*g +: 2]))
      else $error("coarse write did not apply fine offset");
  end

  a_master_fine_decode: assert property (@(posedge MCLK) disable iff (RST) // [RQ9]
    fine_en |-> master_att - AW'(MASTER_COARSE_GAIN) * 4 == AW'(mfine_act_r))
    else $error("master fine decode wrong");
  a_reset_values: assert property (@(posedge MCLK) // [RQ1]
    $past(RST) |-> rise_r == 8'h00 && fall_r == 8'h00 && ch_fine_r == 8'h80)
    else $error("control registers wrong after reset");
endmodule

// file: tb_top.sv
// self-checking bench for the soft volume block
`timescale 1ns/1ps
module tb_top;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0][7:0] cg = '0;
  logic [2:0] cw = '0;
  logic [7:0] mg = 8'h00;
  logic mw = 1'b0;
  logic [2:0][11:0] att;
  logic [11:0] exp_q[$];
  logic [11:0] got = '0;
  logic got_vld = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] d;
  logic [7:0] ra;
  int errors = 0;
  int check_count = 0;
  int seed = 43712;
  always #10 MCLK = ~MCLK;
  svf_host svf_host_inst (.clk(MCLK), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
  svf_top #(.TICK_CYC(4)) svf_top_inst (.MCLK(MCLK), .RST(RST), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .CH_COARSE_GAIN(cg),
    .CH_COARSE_WR(cw), .MASTER_COARSE_GAIN(mg), .MASTER_COARSE_WR(mw), .CH_ATTEN(att));
  task automatic check(input logic [11:0] e, input logic [11:0] a);
    check_count++;
    if (a !== e) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  // monitor: oldest note against each result
  always @(posedge MCLK) begin
    rd_d <= rd;
    if (rd_d || got_vld) begin
      check(exp_q.pop_front(), rd_d ? {4'h0, rdata} : got);
    end
  end
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    svf_host_inst.acc(1'b1, a, v);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({4'h0, e});
    svf_host_inst.acc(1'b0, a, 8'h00);
  endtask
  task automatic post(input logic [11:0] e, input logic [11:0] v);
    exp_q.push_back(e);
    got <= v;
    got_vld <= 1'b1;
    @(posedge MCLK);
    got_vld <= 1'b0;
  endtask
  task automatic settle(input int ch, input logic [11:0] e);
    repeat (200) @(posedge MCLK);
    post(e, att[ch]);
  endtask
  task automatic cwr(input int ch);
    if (ch == 3) mw <= 1'b1;
    else cw[ch] <= 1'b1;
    @(posedge MCLK);
    mw <= 1'b0;
    cw <= '0;
  endtask
  // cycles between two steps of channel 0, then back to fast rates
  task automatic rate(input logic [7:0] a, input logic [7:0] cfg, input logic [7:0] g,
                      input int n);
    int c;
    logic [11:0] v;
    wrr(a, cfg);
    cg[0] <= g;
    for (int k = 0; k < 2; k++) begin
      v = att[0];
      c = 0;
      while (att[0] === v && c < 999) begin
        @(posedge MCLK);
        c++;
      end
    end
    post(12'((n + 1) * 4), 12'(c));
    wrr(8'h37, 8'h20);
    wrr(8'h38, 8'h20);
    settle(0, {2'b00, g, 2'b00});
  endtask
  initial begin
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    rdchk(8'h37, 8'h00);
    rdchk(8'h38, 8'h00);
    rdchk(8'h3F, 8'h80);
    rdchk(8'h40, 8'h00);
    $display("reset values done");
    for (int k = 0; k < 3; k++) begin
      d = 8'($random(seed)) & 8'h07;
      rate(8'h38, (k > 0 ? 8'h20 : 8'h00) | d, 8'h0A, k > 0 ? int'(d) : 3);
      d = 8'($random(seed)) & 8'h07;
      rate(8'h37, (k > 0 ? 8'h20 : 8'h00) | d, 8'h00, k > 0 ? int'(d) : 3);
    end
    $display("ramp rates done");
    foreach (exp_q[i]) d = 8'h00;
    for (int k = 0; k < 5; k++) begin
      d = 8'($random(seed));
      ra = k == 0 ? 8'h37 : k == 1 ? 8'h38 : k == 2 ? 8'h3F : k == 3 ? 8'h40 : 8'h41;
      wrr(ra, d);
      rdchk(ra, k == 4 ? 8'h00 : d & (k < 2 ? 8'h3F : k == 2 ? 8'hFF : 8'h03));
    end
    rdchk(8'h41, 8'h00);
    $display("register access done");
    wrr(8'h37, 8'h20);
    wrr(8'h38, 8'h20);
    wrr(8'h40, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wrr(8'h3F, 8'h80 | 8'(c) | 8'((3 - c) << 4));
      settle(0, 12'(c));
      settle(2, 12'(3 - c));
    end
    cg[1] <= 8'h05;
    mg <= 8'h01;
    wrr(8'h40, 8'h02);
    wrr(8'h3F, 8'h8C);
    settle(1, 12'd29);
    wrr(8'h3F, 8'h7F);
    settle(1, 12'd24);
    wrr(8'h3F, 8'hC0);
    wrr(8'h40, 8'h00);
    settle(1, 12'd29);
    cwr(1);
    settle(1, 12'd26);
    cwr(3);
    settle(1, 12'd24);
    $display("fine gain done");
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge MCLK);
    errors++;
    print_verdict();
  end
endmodule
